// ### sboc_cfg.svh
// Timing counts and configuration defaults for the bus ownership control block.
`ifndef SBOC_CFG_SVH
`define SBOC_CFG_SVH
`define SBOC_DATA_W        128
`define SBOC_PAR_W         4
`define SBOC_CMD_W         4
`define SBOC_ADDR_HI       39
`define SBOC_ADDR_LO       4
`define SBOC_RWGAP_W       4
`define SBOC_FILL_GAP      3'h5
`define SBOC_CNT_W         4
`define SBOC_CMD_NOP       4'h0
`endif

// ### sboc_pkg.sv
// Types shared by the bus ownership control block.
`include "sboc_cfg.svh"
package sboc_pkg;
  typedef struct packed {
    logic [`SBOC_CMD_W-1:0]                cmd;
    logic [`SBOC_ADDR_HI:`SBOC_ADDR_LO]    addr;
  } sboc_cmdaddr_type;
  typedef struct packed {
    logic [`SBOC_DATA_W-1:0] data;
    logic [`SBOC_PAR_W-1:0]  par;
  } sboc_dbus_type;
  typedef enum logic [1:0] {
    SBOC_CA_DEV  = 2'b00,
    SBOC_CA_SYS  = 2'b01,
    SBOC_CA_BACK = 2'b11
  } sboc_ca_state_type;
  typedef enum logic [2:0] {
    SBOC_D_IDLE  = 3'b000,
    SBOC_D_WRITE = 3'b001,
    SBOC_D_READ  = 3'b011,
    SBOC_D_RWGAP = 3'b010,
    SBOC_D_FILL  = 3'b110,
    SBOC_D_FGAP  = 3'b111,
    SBOC_D_SYS   = 3'b101
  } sboc_d_state_type;
endpackage

// ### sboc_ctrl.sv
// Bus ownership and turnaround control for the shared command/address and data buses.
// ==========================================================================
// Overview of operation
// - Data bus is 128 data plus 4 parity lines, single driver only.
// - Command/address bus is 4-bit command and address bits 39 to 4.
// - Request seen at edge N releases our command/address drivers at that edge.
// - Bus is sampled at end of N+1; system keeps driving while requested.
// - System turns off and drops request to return; contents ignored when dropped.
// - We resume driving the command/address bus at edge N+2.
// - After a private write, stop driving data before SRAM outputs turn on.
// - After fill, no data drive or RAM enable until fifth cycle past last ack.
// - Data-bus request seen at edge N releases our data bus at that edge.
// - Owner drives its bus to a defined value every owned cycle; here only the command/address bus does (NOP), data drives on writes only.
// - RAM enable drops one system cycle after last ack (pipelined), or at the edge that sees the last ack.
// - Back-to-back fills may be pipelined.
// ==========================================================================
`include "sboc_cfg.svh"
module sboc_ctrl
  import sboc_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic                       sys_tick,
  input  wire logic                       addr_bus_req,
  input  wire logic                       cache_idle_request,
  input  wire logic                       data_bus_req,
  input  wire logic                       fill_pending,
  input  wire logic                       data_ack,
  input  wire logic                       last_data_ack,
  input  wire logic                       pipelined_sram_select,
  input  wire logic [`SBOC_RWGAP_W-1:0]   read_write_turnaround_gap,
  input  wire sboc_cmdaddr_type           ca_in,
  input  wire logic                       req_valid,
  input  wire logic                       req_write,
  input  wire sboc_dbus_type              req_data,
  output logic                            req_ready,
  output sboc_cmdaddr_type                ca_out,
  output logic                            ca_oe,
  output sboc_cmdaddr_type                ca_sampled,
  output logic                            ca_sampled_valid,
  output sboc_dbus_type                   dbus_out,
  output logic                            dbus_oe,
  output logic                            ram_oe,
  output logic                            ca_busy
);

  // ==========================================================================
  // Two-entry request buffer.
  // A stall of the data path leaves words here, and the full flag pushes back.
  sboc_dbus_type buf_data_r [2];
  logic          buf_wr_r   [2];
  logic          buf_data_we;
  logic [1:0]    buf_cnt_r, buf_cnt_nxt;
  logic          buf_rd_r, buf_rd_nxt, buf_wp_r, buf_wp_nxt;
  logic          push, pop;

  // Ready is registered from the count so it comes straight from a flip-flop.
  logic          req_ready_nxt;

  // ==========================================================================
  // Command/address ownership.
  sboc_ca_state_type ca_st_r, ca_st_nxt;
  logic              ca_oe_nxt, ca_sv_nxt;
  sboc_cmdaddr_type  ca_out_nxt, ca_smp_nxt;

  always_comb begin
    ca_st_nxt  = ca_st_r;
    ca_oe_nxt  = ca_oe;
    ca_sv_nxt  = 1'b0;
    ca_smp_nxt = ca_sampled;
    ca_out_nxt = ca_out;
    unique case (ca_st_r)
      SBOC_CA_DEV: begin
        if (addr_bus_req) begin
          ca_st_nxt = SBOC_CA_SYS;
          ca_oe_nxt = 1'b0;
        end else begin
          ca_oe_nxt  = 1'b1;
          ca_out_nxt = '{cmd: `SBOC_CMD_NOP, addr: '0};
        end
      end
      SBOC_CA_SYS: begin
        if (addr_bus_req) begin
          ca_sv_nxt  = 1'b1;
          ca_smp_nxt = ca_in;
        end else begin
          ca_st_nxt = SBOC_CA_BACK;
        end
      end
      SBOC_CA_BACK: begin
        // One dead cycle so the system drivers have fully released.
        if (addr_bus_req) begin
          ca_st_nxt = SBOC_CA_SYS;
        end else begin
          ca_st_nxt = SBOC_CA_DEV;
          ca_oe_nxt = 1'b1;
        end
      end
      default: begin
        ca_st_nxt = SBOC_CA_DEV;
        ca_oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ca_st_r          <= SBOC_CA_DEV;
      ca_oe            <= 1'b0;
      ca_sampled_valid <= 1'b0;
      ca_sampled       <= '0;
      ca_out           <= '0;
      ca_busy          <= 1'b0;
    end else begin
      ca_st_r          <= ca_st_nxt;
      ca_oe            <= ca_oe_nxt;
      ca_sampled_valid <= ca_sv_nxt;
      ca_sampled       <= ca_smp_nxt;
      ca_out           <= ca_out_nxt;
      ca_busy          <= (ca_st_nxt != SBOC_CA_DEV);
    end
  end

  // ==========================================================================
  // Data bus ownership and turnaround.
  sboc_d_state_type         d_st_r, d_st_nxt;
  logic [`SBOC_CNT_W-1:0]   cnt_r, cnt_nxt;
  logic                     dbus_oe_nxt, ram_oe_nxt, oe_hold_r, oe_hold_nxt;
  sboc_dbus_type            dbus_out_nxt;
  logic                     head_wr;

  assign head_wr = buf_wr_r[buf_rd_r];
  assign push    = req_valid && req_ready;

  always_comb begin
    d_st_nxt     = d_st_r;
    cnt_nxt      = cnt_r;
    pop          = 1'b0;
    dbus_oe_nxt  = 1'b0;
    dbus_out_nxt = dbus_out;
    ram_oe_nxt   = ram_oe;
    oe_hold_nxt  = oe_hold_r;
    // Pipelined SRAMs keep the enable until the next system tick.
    if (oe_hold_r && sys_tick) begin
      ram_oe_nxt  = 1'b0;
      oe_hold_nxt = 1'b0;
    end
    unique case (d_st_r)
      SBOC_D_IDLE, SBOC_D_WRITE, SBOC_D_READ: begin
        if (data_bus_req && cache_idle_request) begin
          d_st_nxt   = SBOC_D_SYS;
          ram_oe_nxt = 1'b0;
        end else if (fill_pending || cache_idle_request) begin
          d_st_nxt   = SBOC_D_FILL;
          ram_oe_nxt = 1'b0;
        end else if (buf_cnt_r != 2'd0) begin
          pop = 1'b1;
          if (head_wr) begin
            if (d_st_r == SBOC_D_READ && read_write_turnaround_gap != '0) begin
              pop      = 1'b0;
              d_st_nxt = SBOC_D_RWGAP;
              cnt_nxt  = `SBOC_CNT_W'(read_write_turnaround_gap);
            end else begin
              d_st_nxt     = SBOC_D_WRITE;
              dbus_oe_nxt  = 1'b1;
              dbus_out_nxt = buf_data_r[buf_rd_r];
              ram_oe_nxt   = 1'b0;
            end
          end else begin
            d_st_nxt   = SBOC_D_READ;
            ram_oe_nxt = 1'b1;
          end
        end else if (d_st_r == SBOC_D_WRITE) begin
          d_st_nxt = SBOC_D_IDLE;
        end
      end
      SBOC_D_RWGAP: begin
        ram_oe_nxt = 1'b0;
        if (cnt_r <= `SBOC_CNT_W'(1)) begin
          d_st_nxt = SBOC_D_IDLE;
          cnt_nxt  = '0;
        end else begin
          cnt_nxt = cnt_r - `SBOC_CNT_W'(1);
        end
      end
      SBOC_D_FILL: begin
        if (data_bus_req && cache_idle_request) begin
          d_st_nxt = SBOC_D_SYS;
        end else if (data_ack && last_data_ack && sys_tick) begin
          d_st_nxt = SBOC_D_FGAP;
          cnt_nxt  = `SBOC_CNT_W'(`SBOC_FILL_GAP);
        end else if (!fill_pending && !cache_idle_request) begin
          // Nothing pending and no hold any more, so the bus is ours again; avoids a deadlock.
          d_st_nxt = SBOC_D_IDLE;
        end
      end
      SBOC_D_FGAP: begin
        if (fill_pending) begin
          d_st_nxt = SBOC_D_FILL;
        end else if (cnt_r <= `SBOC_CNT_W'(1)) begin
          d_st_nxt = SBOC_D_IDLE;
        end else begin
          cnt_nxt = cnt_r - `SBOC_CNT_W'(1);
        end
      end
      SBOC_D_SYS: begin
        if (!data_bus_req) begin
          d_st_nxt = SBOC_D_FILL;
        end
      end
      default: d_st_nxt = SBOC_D_IDLE;
    endcase
    // System-side cache read ending: enable drops per the SRAM style.
    if (ram_oe && data_ack && last_data_ack && sys_tick && d_st_r == SBOC_D_READ) begin
      if (pipelined_sram_select) begin
        oe_hold_nxt = 1'b1;
        ram_oe_nxt  = 1'b1;
      end else begin
        ram_oe_nxt = 1'b0;
      end
      d_st_nxt = SBOC_D_IDLE;
      pop      = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      d_st_r    <= SBOC_D_IDLE;
      cnt_r     <= '0;
      dbus_oe   <= 1'b0;
      dbus_out  <= '0;
      ram_oe    <= 1'b0;
      oe_hold_r <= 1'b0;
    end else begin
      d_st_r    <= d_st_nxt;
      cnt_r     <= cnt_nxt;
      dbus_oe   <= dbus_oe_nxt;
      dbus_out  <= dbus_out_nxt;
      ram_oe    <= ram_oe_nxt;
      oe_hold_r <= oe_hold_nxt;
    end
  end

  // ==========================================================================
  // Buffer pointer and count update.
  always_comb begin
    buf_wp_nxt    = buf_wp_r ^ push;
    buf_rd_nxt    = buf_rd_r ^ pop;
    buf_cnt_nxt   = buf_cnt_r + 2'(push) - 2'(pop);
    req_ready_nxt = (buf_cnt_nxt != 2'd2);
    buf_data_we   = push;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      buf_wp_r  <= 1'b0;
      buf_rd_r  <= 1'b0;
      buf_cnt_r <= 2'd0;
      req_ready <= 1'b0;
    end else begin
      buf_wp_r  <= buf_wp_nxt;
      buf_rd_r  <= buf_rd_nxt;
      buf_cnt_r <= buf_cnt_nxt;
      req_ready <= req_ready_nxt;
    end
  end

  // Storage has no reset; contents are only read when the count says so.
  always_ff @(posedge clock) begin
    if (buf_data_we) begin
      buf_data_r[buf_wp_r] <= req_data;
      buf_wr_r[buf_wp_r]   <= req_write;
    end
  end

endmodule

// ### sboc_monitor.sv
// Port checker for the bus ownership control block.
// ====================================================
// Checker
module sboc_monitor
  import sboc_pkg::*;
(
  input wire logic             clock,
  input wire logic             reset,
  input wire logic             sys_tick,
  input wire logic             addr_bus_req,
  input wire logic             cache_idle_request,
  input wire logic             data_bus_req,
  input wire logic             fill_pending,
  input wire logic             data_ack,
  input wire logic             last_data_ack,
  input wire sboc_cmdaddr_type ca_in,
  input wire logic             ca_oe,
  input wire sboc_cmdaddr_type ca_sampled,
  input wire logic             ca_sampled_valid,
  input wire logic             dbus_oe,
  input wire logic             ram_oe,
  input wire logic             ca_busy
);
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // The dead cycle guards against both parties driving the bus at once.
  sequence dead_then_drive;
    !ca_oe ##1 !ca_oe ##[1:2] ca_oe;
  endsequence
  ca_release_a: assert property (
    addr_bus_req && ca_oe |=> !ca_oe && ca_busy) else $error("bus not released");
  ca_resume_a: assert property (
    $fell(addr_bus_req) && ca_busy |-> dead_then_drive) else $error("bad resume");
  owner_excl_a: assert property (
    ca_busy |-> !ca_oe) else $error("driving while system owns bus");
  sample_gate_a: assert property (
    ca_sampled_valid |-> $past(addr_bus_req) && ca_busy) else $error("stray sample");
  sample_value_a: assert property (
    ca_sampled_valid |-> ca_sampled == $past(ca_in)) else $error("wrong sample");
  data_single_a: assert property (
    !(dbus_oe && ram_oe)) else $error("two data drivers");
  data_yield_a: assert property (
    data_bus_req && cache_idle_request |-> ##2 !dbus_oe && !ram_oe)
    else $error("data bus not yielded");
  fill_quiet_a: assert property (
    fill_pending && sys_tick && data_ack && last_data_ack |=> (!dbus_oe && !ram_oe)[*4])
    else $error("drive too soon after fill");
endmodule

bind sboc_ctrl sboc_monitor i_sboc_monitor (
  .clock              (clock),
  .reset              (reset),
  .sys_tick           (sys_tick),
  .addr_bus_req       (addr_bus_req),
  .cache_idle_request (cache_idle_request),
  .data_bus_req       (data_bus_req),
  .fill_pending       (fill_pending),
  .data_ack           (data_ack),
  .last_data_ack      (last_data_ack),
  .ca_in              (ca_in),
  .ca_oe              (ca_oe),
  .ca_sampled         (ca_sampled),
  .ca_sampled_valid   (ca_sampled_valid),
  .dbus_oe            (dbus_oe),
  .ram_oe             (ram_oe),
  .ca_busy            (ca_busy)
);

// ### sboc_sys_model.sv
// System chipset model for the command/address and data bus handoffs.
module sboc_sys_model
  import sboc_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             take_ca,
  input  wire logic             take_data,
  input  wire sboc_cmdaddr_type ca_val,
  input  wire logic             ca_oe,
  output logic                  addr_bus_req,
  output logic                  cache_idle_request,
  output logic                  data_bus_req,
  output sboc_cmdaddr_type      ca_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_bus_req = 0;
    cache_idle_request = 0;
    data_bus_req = 0;
    ca_in = '0;
  end
  // Idle first, data request later; on return the data request drops a cycle ahead.
  // Inputs are read at the edge, so a bench change just after it cannot race the model.
  always @(posedge clock) begin
    addr_bus_req <= #2 take_ca;
    data_bus_req <= #2 take_data && cache_idle_request;
    cache_idle_request <= #2 take_data || data_bus_req;
  end
  // Drive only once the block has let go; a released bus shows no stale value.
  always @(posedge clock) begin
    #3;
    ca_in <= (addr_bus_req && !ca_oe) ? ca_val : ~ca_in;
  end
endmodule

// ### sboc_ctrl_bench.sv
// Self-checking bench for the bus ownership control block.
module sboc_ctrl_bench
  import sboc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, reset = 1, sys_tick = 0, take_ca = 0, take_data = 0;
  logic fill_pending = 0, data_ack = 0, last_data_ack = 0, req_valid = 0;
  logic req_write = 0, pipelined_sram_select = 0, req_ready, ca_oe;
  logic ca_sampled_valid, dbus_oe, ram_oe, ca_busy;
  logic addr_bus_req, cache_idle_request, data_bus_req;
  logic [3:0] read_write_turnaround_gap = 4'h6;
  sboc_cmdaddr_type ca_in, ca_out, ca_sampled;
  sboc_cmdaddr_type ca_val = '{cmd: 4'h4, addr: 36'h9_abcd_1234};
  sboc_dbus_type req_data = '0, dbus_out;
  int err_total = 0, tests_run = 0, cyc = 0, tc = 0;
  sboc_ctrl i_sboc_ctrl (
    .clock                     (clock),
    .reset                     (reset),
    .sys_tick                  (sys_tick),
    .addr_bus_req              (addr_bus_req),
    .cache_idle_request        (cache_idle_request),
    .data_bus_req              (data_bus_req),
    .fill_pending              (fill_pending),
    .data_ack                  (data_ack),
    .last_data_ack             (last_data_ack),
    .pipelined_sram_select     (pipelined_sram_select),
    .read_write_turnaround_gap (read_write_turnaround_gap),
    .ca_in                     (ca_in),
    .req_valid                 (req_valid),
    .req_write                 (req_write),
    .req_data                  (req_data),
    .req_ready                 (req_ready),
    .ca_out                    (ca_out),
    .ca_oe                     (ca_oe),
    .ca_sampled                (ca_sampled),
    .ca_sampled_valid          (ca_sampled_valid),
    .dbus_out                  (dbus_out),
    .dbus_oe                   (dbus_oe),
    .ram_oe                    (ram_oe),
    .ca_busy                   (ca_busy)
  );
  sboc_sys_model i_sboc_sys_model (
    .clock              (clock),
    .take_ca            (take_ca),
    .take_data          (take_data),
    .ca_val             (ca_val),
    .ca_oe              (ca_oe),
    .addr_bus_req       (addr_bus_req),
    .cache_idle_request (cache_idle_request),
    .data_bus_req       (data_bus_req),
    .ca_in              (ca_in)
  );
  // ===================================================
  // Clocks and timeout
  always #10 clock = ~clock;
  // One system edge every four core cycles.
  always @(posedge clock) begin
    tc <= tc + 1;
    sys_tick <= (tc % 4 == 3);
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      err_total++;
      summarize;
    end
  end
  // ===================================================
  // Helpers
  task tick;
    @(posedge clock);
    #2;
  endtask
  task chk(string name, logic [131:0] seen, logic [131:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Leaves the request up after acceptance so pushes can run back to back.
  task push(logic [7:0] k, logic wr);
    int i;
    req_valid = 1;
    req_write = wr;
    req_data = '{data: {16{k}}, par: 4'h0};
    i = 0;
    while (req_ready !== 1'b1 && i < 50) begin
      tick;
      i++;
    end
    tick;
  endtask
  task get(output sboc_dbus_type w, output int n);
    n = 0;
    while (dbus_oe !== 1'b1 && n < 60) begin
      tick;
      n++;
    end
    w = dbus_out;
    tick;
  endtask
  // A read that the system closes with its final acknowledge; n counts cycles until the enable drops.
  task sys_read(logic sel, output int n);
    pipelined_sram_select = sel;
    push(8'h77, 1'b0);
    req_valid = 0;
    while (ram_oe !== 1'b1) tick;
    while (sys_tick !== 1'b1) tick;
    data_ack = 1;
    last_data_ack = 1;
    tick;
    data_ack = 0;
    last_data_ack = 0;
    n = 0;
    while (ram_oe !== 1'b0 && n < 20) begin
      tick;
      n++;
    end
  endtask
  // ===================================================
  // Scenarios
  task t_ca;
    take_ca = 1;
    repeat (3) tick;
    chk("ca_oe", ca_oe, 0);
    chk("ca_busy", ca_busy, 1);
    repeat (2) tick;
    chk("ca_sampled", ca_sampled, ca_val);
    chk("ca_valid", ca_sampled_valid, 1);
    take_ca = 0;
    repeat (2) tick;
    chk("ca_oe_dead", ca_oe, 0);
    tick;
    chk("ca_oe_back", ca_oe, 1);
    chk("ca_out_nop", ca_out, 40'h0);
  endtask
  // Fill the buffer while the system holds the data bus, then drain in order.
  task t_buf;
    sboc_dbus_type w;
    int n;
    take_data = 1;
    repeat (3) tick;
    push(8'h11, 1'b1);
    push(8'h22, 1'b1);
    req_data = '{data: {16{8'h33}}, par: 4'h0};
    repeat (2) tick;
    chk("req_ready", req_ready, 0);
    req_valid = 0;
    chk("dbus_oe_held", dbus_oe, 0);
    take_data = 0;
    get(w, n);
    chk("word0", w, {{16{8'h11}}, 4'h0});
    get(w, n);
    chk("word1", w, {{16{8'h22}}, 4'h0});
  endtask
  task t_fill;
    sboc_dbus_type w;
    int n;
    fill_pending = 1;
    repeat (8) tick;
    push(8'h44, 1'b1);
    req_valid = 0;
    while (sys_tick !== 1'b1) tick;
    // No command acknowledge is raised here; the final data acknowledge closes the fill.
    data_ack = 1;
    last_data_ack = 1;
    tick;
    data_ack = 0;
    last_data_ack = 0;
    fill_pending = 0;
    get(w, n);
    chk("fill_gap", n >= 4, 1'h1);
    chk("fill_word", w, {{16{8'h44}}, 4'h0});
  endtask
  // Read then write through the turnaround gap, then system reads in both SRAM styles.
  task t_read;
    sboc_dbus_type w;
    int n;
    push(8'h55, 1'b0);
    push(8'h66, 1'b1);
    req_valid = 0;
    chk("ram_oe_read", ram_oe, 1);
    while (ram_oe !== 1'b0) tick;
    get(w, n);
    chk("rw_gap", n >= read_write_turnaround_gap, 1'h1);
    chk("rw_word", w, {{16{8'h66}}, 4'h0});
    sys_read(1'b0, n);
    chk("oe_flow", n, 0);
    sys_read(1'b1, n);
    chk("oe_pipe", n, 4);
  endtask
  task summarize;
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (4) @(posedge clock);
    #2;
    reset = 0;
    repeat (2) tick;
    t_ca;
    t_buf;
    t_fill;
    t_read;
    summarize;
  end
endmodule
